// [rtl/fds_supervisor.sv]
`timescale 1ns/1ps
`default_nettype none
module fds_supervisor
  import fds_pkg::*;
#(
  parameter logic [CNT_W-1:0] OL_DEGLITCH_CYCLES = OL_DEGLITCH_CYC,
  parameter logic [CNT_W-1:0] RETRY_CYCLES = RETRY_CYC
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic enable_in,
  input wire logic latch_select,
  input wire logic diagnostics_gate,
  input wire logic current_limit_fault,
  input wire logic relative_thermal_fault,
  input wire logic absolute_thermal_fault,
  input wire logic thermal_hys_met,
  input wire logic open_load_threshold,
  input wire logic reverse_polarity,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic channel_on,
  output logic current_limit_active,
  output logic pullup_en,
  output logic fault_flag_n_o,
  output logic fault_flag_n_oe,
  output fds_sense_t sense_output,
  output logic sense_output_oe,
  output logic irq
);

  logic [N_IN-1:0] pin_raw;
  logic [N_IN-1:0] pin_s;
  logic en_s;
  logic latch_s;
  logic diag_s;
  logic hys_s;
  logic rev_s;
  fds_state_t state_r;
  logic [CNT_W-1:0] retry_cnt_r;
  logic retry_done;
  logic abs_seen_r;
  logic oc_q;
  logic rel_q;
  logic abs_q;
  logic ol_q;
  logic fault_active;
  logic [N_EV-1:0] ev_level;
  logic [N_EV-1:0] ev_prev_r;
  logic [N_EV-1:0] ev_pulse;
  logic [N_EV-1:0] irq_stat_r;
  logic [N_EV-1:0] irq_mask_r;
  logic [N_EV-1:0] w1c;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] rdata_nxt;

  fds_deg_if oc_dg ();
  fds_deg_if rel_dg ();
  fds_deg_if abs_dg ();
  fds_deg_if ol_dg ();

  // Every control and fault pin crosses two flops before any logic sees it; the register port is used unsynchronised
  assign pin_raw[IN_EN] = enable_in;
  assign pin_raw[IN_LATCH] = latch_select;
  assign pin_raw[IN_DIAG] = diagnostics_gate;
  assign pin_raw[IN_OC] = current_limit_fault;
  assign pin_raw[IN_REL] = relative_thermal_fault;
  assign pin_raw[IN_ABS] = absolute_thermal_fault;
  assign pin_raw[IN_HYS] = thermal_hys_met;
  assign pin_raw[IN_OL] = open_load_threshold;
  assign pin_raw[IN_REV] = reverse_polarity;

  fds_sync u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in(pin_raw),
    .sync_out(pin_s)
  );

  assign en_s = pin_s[IN_EN];
  assign latch_s = pin_s[IN_LATCH];
  assign diag_s = pin_s[IN_DIAG];
  assign hys_s = pin_s[IN_HYS];
  assign rev_s = pin_s[IN_REV];

  // Raw fault levels; overcurrent only counts while driving the load
  assign oc_dg.raw = pin_s[IN_OC] && en_s && (state_r == ST_ON);
  assign rel_dg.raw = pin_s[IN_REL];
  assign abs_dg.raw = pin_s[IN_ABS];
  // Open-load compare is meaningful only with the pull-up switched in
  assign ol_dg.raw = pin_s[IN_OL] && pullup_en;

  fds_deglitch #(.CYCLES(OC_DEGLITCH_CYC)) u_oc_dg (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .dg(oc_dg.fault_flag_n)
  );

  fds_deglitch #(.CYCLES(REL_DEGLITCH_CYC)) u_rel_dg (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .dg(rel_dg.fault_flag_n)
  );

  fds_deglitch #(.CYCLES(ABS_DEGLITCH_CYC)) u_abs_dg (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .dg(abs_dg.fault_flag_n)
  );

  fds_deglitch #(.CYCLES(OL_DEGLITCH_CYCLES)) u_ol_dg (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .dg(ol_dg.fault_flag_n)
  );

  assign oc_q = oc_dg.qual;
  assign rel_q = rel_dg.qual;
  assign abs_q = abs_dg.qual;
  assign ol_q = ol_dg.qual;

  // Retry wait runs only while shut down, saturating at its end
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      retry_cnt_r <= '0;
    else if (state_r != ST_RETRY)
      retry_cnt_r <= '0;
    else if (retry_cnt_r != RETRY_CYCLES)
      retry_cnt_r <= retry_cnt_r + 1'b1;
  end

  assign retry_done = (retry_cnt_r == RETRY_CYCLES);

  // Absolute shutdowns in auto-retry also wait for the hysteresis to clear; latch-off and its latch-low exit do not
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      abs_seen_r <= 1'b0;
    else if (state_r == ST_ON && abs_q)
      abs_seen_r <= 1'b1;
    else if (state_r == ST_ON || state_r == ST_OFF)
      abs_seen_r <= 1'b0;
  end

  // Channel sequencing: on, thermal shutdown wait, latched off
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      state_r <= ST_OFF;
    else
    begin
      unique case (state_r)
        ST_OFF:
        begin
          if (en_s)
            state_r <= ST_ON;
        end
        ST_ON:
        begin
          if (rel_q || abs_q)
            state_r <= ST_RETRY;
          else if (!en_s)
            state_r <= ST_OFF;
        end
        ST_RETRY:
        begin
          // Enable low mid-wait still serves the full wait first
          if (retry_done)
          begin
            if (latch_s && en_s)
              state_r <= ST_LATCHED;
            else if (!en_s)
              state_r <= ST_OFF;
            else if (!abs_seen_r || hys_s)
              state_r <= ST_ON;
          end
        end
        ST_LATCHED:
        begin
          // Latch low resumes in auto-retry; enable low parks off
          if (!en_s)
            state_r <= ST_OFF;
          else if (!latch_s)
            state_r <= ST_ON;
        end
      endcase
    end
  end

  // Anything that makes the flag pull low
  assign fault_active = (state_r == ST_ON && oc_q)
    || (state_r == ST_RETRY)
    || (state_r == ST_LATCHED)
    || (state_r == ST_OFF && ol_q);

  // Pin drivers, all from flops
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      channel_on <= 1'b0;
      current_limit_active <= 1'b0;
      pullup_en <= 1'b0;
    end
    else
    begin
      // Reverse supply overrides every command
      channel_on <= rev_s || (state_r == ST_ON);
      current_limit_active <= (state_r == ST_ON) && oc_q;
      // Pull-up switched by the gate to keep standby current low
      pullup_en <= (state_r == ST_OFF) && !en_s && diag_s;
    end
  end

  // Diagnostic reporting, gated by the diagnostics input
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fault_flag_n_oe <= 1'b0;
      sense_output <= SNS_ZERO;
      sense_output_oe <= 1'b0;
    end
    else if (diag_s)
    begin
      fault_flag_n_oe <= fault_active;
      sense_output_oe <= 1'b1;
      if (fault_active)
        sense_output <= SNS_FAULT;
      else if (state_r == ST_ON)
        sense_output <= SNS_LOAD;
      else
        sense_output <= SNS_ZERO;
    end
    else if (en_s)
    begin
      // Protection keeps running; only reporting is muted
      fault_flag_n_oe <= 1'b0;
      sense_output <= SNS_ZERO;
      sense_output_oe <= 1'b1;
    end
    else
    begin
      fault_flag_n_oe <= 1'b0;
      sense_output <= SNS_ZERO;
      sense_output_oe <= 1'b0;
    end
  end

  // Open-drain flag only ever pulls low
  assign fault_flag_n_o = 1'b0;

  // Event levels, captured on their rising edge
  assign ev_level[EV_OC] = oc_q;
  assign ev_level[EV_REL] = rel_q;
  assign ev_level[EV_ABS] = abs_q;
  assign ev_level[EV_OL] = ol_q;
  assign ev_level[EV_RETRY] = (state_r == ST_ON) && abs_seen_r;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      ev_prev_r <= '0;
    else
      ev_prev_r <= ev_level;
  end

  assign ev_pulse = ev_level & ~ev_prev_r;

  // Write-one-to-clear; a new event in the same cycle survives
  assign w1c = (reg_wr && reg_addr == REG_IRQ_STAT) ? reg_wdata[N_EV-1:0] : '0;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      irq_stat_r <= IRQ_STAT_RST[N_EV-1:0];
    else
      irq_stat_r <= (irq_stat_r & ~w1c) | ev_pulse;
  end

  // Mask steers which events reach the interrupt line
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      irq_mask_r <= IRQ_MASK_RST[N_EV-1:0];
    else if (reg_wr && reg_addr == REG_IRQ_MASK)
      irq_mask_r <= reg_wdata[N_EV-1:0];
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // Live view of the supervisor
  assign status_word = {rev_s,
                        state_r == ST_RETRY,
                        state_r == ST_LATCHED,
                        ol_q,
                        abs_q,
                        rel_q,
                        current_limit_active,
                        channel_on};

  // Read decode; unmapped addresses read as zero
  always_comb
  begin
    rdata_nxt = '0;
    unique case (reg_addr)
      REG_STATUS: rdata_nxt = status_word;
      REG_IRQ_STAT: rdata_nxt = {{(DATA_W-N_EV){1'b0}}, irq_stat_r};
      REG_IRQ_MASK: rdata_nxt = {{(DATA_W-N_EV){1'b0}}, irq_mask_r};
      default: rdata_nxt = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= '0;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
    else
      reg_rdata <= '0;
  end

endmodule : fds_supervisor
`default_nettype wire

// [shared/fds_pkg.sv]
package fds_pkg;
  // Clock and counter sizing
  localparam int CLK_PERIOD_NS = 50;
  localparam int CNT_W = 20;
  // Qualification and retry times in ns; retry value is a plain default
  localparam int OC_DEGLITCH_NS = 2500;
  localparam int REL_DEGLITCH_NS = 2500;
  localparam int ABS_DEGLITCH_NS = 20000;
  localparam int OL_DEGLITCH_NS = 700000;
  localparam int RETRY_TIME_NS = 5000000;
  // Cycle counts, least times rounded up
  localparam logic [CNT_W-1:0] OC_DEGLITCH_CYC =
    CNT_W'((OC_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] REL_DEGLITCH_CYC =
    CNT_W'((REL_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ABS_DEGLITCH_CYC =
    CNT_W'((ABS_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] OL_DEGLITCH_CYC =
    CNT_W'((OL_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RETRY_CYC =
    CNT_W'((RETRY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h1;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h2;
  localparam logic [DATA_W-1:0] IRQ_MASK_RST = 8'h00;
  localparam logic [DATA_W-1:0] IRQ_STAT_RST = 8'h00;
  // Event bit positions in status and mask
  localparam int EV_OC = 0;
  localparam int EV_REL = 1;
  localparam int EV_ABS = 2;
  localparam int EV_OL = 3;
  localparam int EV_RETRY = 4;
  localparam int N_EV = 5;
  // Pin input positions ahead of the synchroniser
  localparam int IN_EN = 0;
  localparam int IN_LATCH = 1;
  localparam int IN_DIAG = 2;
  localparam int IN_OC = 3;
  localparam int IN_REL = 4;
  localparam int IN_ABS = 5;
  localparam int IN_HYS = 6;
  localparam int IN_OL = 7;
  localparam int IN_REV = 8;
  localparam int N_IN = 9;
  typedef enum logic [1:0] {ST_OFF, ST_ON, ST_RETRY, ST_LATCHED} fds_state_t;
  typedef enum logic [1:0] {SNS_ZERO, SNS_LOAD, SNS_FAULT} fds_sense_t;
endpackage : fds_pkg

// [shared/fds_deg_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface fds_deg_if;
  logic raw;
  logic qual;
  modport src (output raw, input qual);
  modport fault_flag_n (input raw, output qual);
endinterface : fds_deg_if
`default_nettype wire

// [rtl/fds_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module fds_sync
  import fds_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [N_IN-1:0] async_in,
  output logic [N_IN-1:0] sync_out
);
  logic [N_IN-1:0] meta_r;
  // Two stages per pin; first stage feeds only the second
  for (genvar i = 0; i < N_IN; i++)
  begin : g_bit
    always_ff @(posedge ref_clk or negedge resetn)
    begin
      if (!resetn)
      begin
        meta_r[i] <= 1'b0;
        sync_out[i] <= 1'b0;
      end
      else
      begin
        meta_r[i] <= async_in[i];
        sync_out[i] <= meta_r[i];
      end
    end
  end
endmodule : fds_sync
`default_nettype wire

// [rtl/fds_deglitch.sv]
`timescale 1ns/1ps
`default_nettype none
module fds_deglitch
  import fds_pkg::*;
#(
  parameter logic [CNT_W-1:0] CYCLES = OC_DEGLITCH_CYC
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  fds_deg_if.fault_flag_n dg
);
  logic [CNT_W-1:0] cnt_r;
  // Timer restarts on any drop of the raw level
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      cnt_r <= '0;
    else if (!dg.raw)
      cnt_r <= '0;
    else if (cnt_r != CYCLES)
      cnt_r <= cnt_r + 1'b1;
  end
  // Qualified only at full interval; drops at once with raw
  assign dg.qual = dg.raw && (cnt_r == CYCLES);
endmodule : fds_deglitch
`default_nettype wire

// [test/fds_supervisor_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module fds_supervisor_monitor
  import fds_pkg::*;
#(
  parameter logic [CNT_W-1:0] OL_DEGLITCH_CYCLES = OL_DEGLITCH_CYC,
  parameter logic [CNT_W-1:0] RETRY_CYCLES = RETRY_CYC
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic enable_in,
  input wire logic diagnostics_gate,
  input wire logic current_limit_fault,
  input wire logic relative_thermal_fault,
  input wire logic absolute_thermal_fault,
  input wire logic open_load_threshold,
  input wire logic reverse_polarity,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic channel_on,
  input wire logic current_limit_active,
  input wire logic pullup_en,
  input wire logic fault_flag_n_oe,
  input wire fds_sense_t sense_output,
  input wire logic sense_output_oe,
  input wire logic irq
);
  localparam int QLIM = int'(RETRY_CYCLES) + 8;
  localparam int HMAX = int'(RETRY_CYCLES) + 50;
  int oc_cnt;
  int hot_cnt;
  int quiet_cnt;
  logic busy;
  assign busy = enable_in | current_limit_fault | relative_thermal_fault |
    absolute_thermal_fault | open_load_threshold | reverse_polarity;
  // Raw run lengths; sync delay is allowed for in the properties
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      oc_cnt <= 0;
    else
      oc_cnt <= current_limit_fault ? oc_cnt + 1 : 0;
  // Reverse supply overrides shutdown, so it restarts the count
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      hot_cnt <= 0;
    else
      hot_cnt <= (relative_thermal_fault && !reverse_polarity) ? hot_cnt + 1 : 0;
  // Saturates past a full retry wait so any old shutdown has ended
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      quiet_cnt <= 0;
    else
      quiet_cnt <= busy ? 0 : (quiet_cnt < QLIM ? quiet_cnt + 1 : quiet_cnt);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  reverse_on_a: assert property (reverse_polarity [*6] |-> channel_on)
    else $error("reverse supply did not turn channel on");
  off_hiz_a: assert property ((!diagnostics_gate && !enable_in) [*6] |->
    !fault_flag_n_oe && !sense_output_oe)
    else $error("flag or sense driven with gate low and channel off");
  on_quiet_a: assert property ((!diagnostics_gate && enable_in) [*6] |->
    !fault_flag_n_oe && sense_output_oe && sense_output == SNS_ZERO)
    else $error("reporting not suppressed with gate low and channel on");
  flag_sense_a: assert property (fault_flag_n_oe |-> sense_output_oe &&
    sense_output == SNS_FAULT)
    else $error("flag low without sense at fault level");
  thermal_off_a: assert property (hot_cnt >= 60 && hot_cnt < HMAX |-> !channel_on)
    else $error("channel stayed on under thermal fault");
  oc_deglitch_a: assert property ($rose(current_limit_active) |->
    $past(oc_cnt, 4) >= 45)
    else $error("current limit recognised before deglitch time");
  quiet_release_a: assert property (quiet_cnt == QLIM |-> !fault_flag_n_oe &&
    (!sense_output_oe || sense_output == SNS_ZERO))
    else $error("flag or sense not released when idle and fault free");
  oc_seen_c: cover property ($rose(current_limit_active));
  ol_flag_c: cover property (pullup_en && fault_flag_n_oe);
  irq_c: cover property (irq);
  shut_c: cover property ($fell(channel_on));
endmodule : fds_supervisor_monitor
bind fds_supervisor fds_supervisor_monitor #(.OL_DEGLITCH_CYCLES(OL_DEGLITCH_CYCLES),
  .RETRY_CYCLES(RETRY_CYCLES)) u_mon (.ref_clk, .resetn, .enable_in, .diagnostics_gate,
  .current_limit_fault, .relative_thermal_fault, .absolute_thermal_fault,
  .open_load_threshold, .reverse_polarity, .reg_rd, .reg_rdata, .channel_on,
  .current_limit_active, .pullup_en, .fault_flag_n_oe, .sense_output, .sense_output_oe,
  .irq);
`default_nettype wire

// [test/fds_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fds_host_model
  import fds_pkg::*;
(
  input wire logic ref_clk,
  input wire logic flag_o,
  input wire logic flag_oe,
  input wire fds_sense_t sense,
  input wire logic sense_oe,
  output logic flag_line,
  output logic [1:0] sense_line
);
  logic [1:0] last_r;
  // Flag line has a pull-up, so a released flag reads high
  assign flag_line = flag_oe ? flag_o : 1'b1;
  // Undriven sense floats; the ADC sees the inverse of the last level
  assign sense_line = sense_oe ? sense : ~last_r;
  always_ff @(posedge ref_clk)
    if (sense_oe)
      last_r <= sense;
endmodule : fds_host_model
`default_nettype wire

// [test/fault_diag_supervisor_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module fault_diag_supervisor_tb_top
  import fds_pkg::*;
  ;
  logic ref_clk, resetn, enable_in, latch_select, diagnostics_gate, thermal_hys_met;
  logic current_limit_fault, relative_thermal_fault, absolute_thermal_fault;
  logic open_load_threshold, reverse_polarity, reg_wr, reg_rd, channel_on, irq;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic current_limit_active, pullup_en, fault_flag_n_o, fault_flag_n_oe;
  logic sense_output_oe, flag_line;
  logic [1:0] sense_line;
  fds_sense_t sense_output;
  int bad_count = 0;
  int cmp_count = 0;
  // Short open-load deglitch and retry counts keep the run brief
  fds_supervisor #(.OL_DEGLITCH_CYCLES(20'h00014), .RETRY_CYCLES(20'h00028)) dut (
    .ref_clk, .resetn, .enable_in, .latch_select, .diagnostics_gate,
    .current_limit_fault, .relative_thermal_fault, .absolute_thermal_fault,
    .thermal_hys_met, .open_load_threshold, .reverse_polarity, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .channel_on, .current_limit_active, .pullup_en,
    .fault_flag_n_o, .fault_flag_n_oe, .sense_output, .sense_output_oe, .irq);
  fds_host_model u_host (.ref_clk, .flag_o(fault_flag_n_o), .flag_oe(fault_flag_n_oe),
    .sense(sense_output), .sense_oe(sense_output_oe), .flag_line, .sense_line);
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic close_out;
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic go(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : go
  // Packed view: on, flag drive, sense drive, sense level
  task automatic pins(input logic [4:0] e);
    #1;
    check("pins", {3'h0, channel_on, fault_flag_n_oe, sense_output_oe, sense_output},
      {3'h0, e});
  endtask : pins
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data is only valid in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check("rdata", reg_rdata, e);
  endtask : rd
  task automatic done(input string n);
    $display("Test %s finished", n);
  endtask : done
  // Hang guard, well beyond the roughly 1500 cycles of the sequence
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    close_out();
  end
  initial
  begin
    {resetn, enable_in, latch_select, diagnostics_gate, thermal_hys_met} = 5'h00;
    {current_limit_fault, relative_thermal_fault, absolute_thermal_fault} = 3'h0;
    {open_load_threshold, reverse_polarity, reg_wr, reg_rd} = 4'h0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    go(3);
    resetn <= 1'b1;
    rd(REG_IRQ_MASK, IRQ_MASK_RST);
    rd(4'hF, 8'h00);
    wr(REG_STATUS, 8'hFF);
    rd(REG_STATUS, 8'h00);
    wr(REG_IRQ_MASK, 8'h1F);
    rd(REG_IRQ_MASK, 8'h1F);
    done("registers");
    diagnostics_gate <= 1'b1;
    go(8);
    pins(5'h04);
    enable_in <= 1'b1;
    go(8);
    pins(5'h15);
    current_limit_fault <= 1'b1;
    go(30);
    current_limit_fault <= 1'b0;
    go(5);
    current_limit_fault <= 1'b1;
    go(40);
    pins(5'h15);
    go(20);
    pins(5'h1E);
    check("irq", {7'h0, irq}, 8'h01);
    check("flag line low", {7'h0, flag_line}, 8'h00);
    rd(REG_IRQ_STAT, 8'h01);
    current_limit_fault <= 1'b0;
    go(8);
    wr(REG_IRQ_STAT, 8'h01);
    rd(REG_IRQ_STAT, 8'h00);
    done("overcurrent");
    relative_thermal_fault <= 1'b1;
    go(60);
    relative_thermal_fault <= 1'b0;
    pins(5'h0E);
    go(20);
    pins(5'h0E);
    go(30);
    pins(5'h15);
    absolute_thermal_fault <= 1'b1;
    go(300);
    absolute_thermal_fault <= 1'b0;
    pins(5'h15);
    go(5);
    absolute_thermal_fault <= 1'b1;
    go(420);
    absolute_thermal_fault <= 1'b0;
    pins(5'h0E);
    go(60);
    pins(5'h0E);
    thermal_hys_met <= 1'b1;
    go(8);
    pins(5'h15);
    rd(REG_IRQ_STAT, 8'h16);
    done("thermal retry");
    // First pass leaves latch-off by latch low, second by enable low
    for (int i = 0; i < 2; i++)
    begin
      latch_select <= 1'b1;
      enable_in <= 1'b1;
      relative_thermal_fault <= 1'b1;
      go(60);
      relative_thermal_fault <= 1'b0;
      go(60);
      #1;
      check("latched", {7'h0, channel_on}, 8'h00);
      go(1);
      latch_select <= (i != 0);
      enable_in <= (i == 0);
      go(8);
      pins((i == 0) ? 5'h15 : 5'h04);
    end
    latch_select <= 1'b0;
    done("latch off");
    enable_in <= 1'b0;
    go(8);
    check("pullup", {7'h0, pullup_en}, 8'h01);
    open_load_threshold <= 1'b1;
    go(15);
    pins(5'h04);
    go(15);
    pins(5'h0E);
    rd(REG_IRQ_STAT, 8'h1E);
    open_load_threshold <= 1'b0;
    go(6);
    pins(5'h04);
    // Long quiet spell so the idle release check gets exercised
    go(44);
    wr(REG_IRQ_MASK, 8'h00);
    #1;
    check("irq masked", {7'h0, irq}, 8'h00);
    wr(REG_IRQ_STAT, 8'h1F);
    rd(REG_IRQ_STAT, 8'h00);
    done("open load off");
    diagnostics_gate <= 1'b0;
    go(8);
    pins(5'h00);
    enable_in <= 1'b1;
    current_limit_fault <= 1'b1;
    go(60);
    pins(5'h14);
    check("limit", {7'h0, current_limit_active}, 8'h01);
    current_limit_fault <= 1'b0;
    diagnostics_gate <= 1'b1;
    open_load_threshold <= 1'b1;
    go(40);
    pins(5'h15);
    check("flag line", {7'h0, flag_line}, 8'h01);
    check("sense line", {6'h0, sense_line}, 8'h01);
    open_load_threshold <= 1'b0;
    enable_in <= 1'b0;
    reverse_polarity <= 1'b1;
    go(8);
    #1;
    check("reverse", {7'h0, channel_on}, 8'h01);
    reverse_polarity <= 1'b0;
    done("gate and reverse");
    close_out();
  end
endmodule : fault_diag_supervisor_tb_top
`default_nettype wire
